// ---- inc/wdt_pkg.sv ----
/*
  Types shared by the watchdog: mode register layout and sleep-state encoding.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package wdt_pkg;

  // mode register fields
  typedef struct packed {
    logic [2:0] fixed_top;
    logic clk_sel_hi;
    logic clk_sel_lo;
    logic [2:0] interval_sel;
  } wdt_mode_t;

  // sleep handling states
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_SETTLE = 2'b10,
    ST_PAUSE = 2'b11
  } wdt_state_t;

endpackage

// ---- inc/wdt_regs.svh ----
/*
  Watchdog register indices, reset values, key and timing counts.
  Assumes a 100 MHz ref_clk; byte address of a register is four times its index.
*/
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// register indices
`define WDT_MODE_IDX 16'hff48
`define WDT_SVC_IDX 16'hff49
`define WDT_STAT_IDX 16'hff4a

// values
`define WDT_MODE_RST 8'h67
`define WDT_SVC_READ 8'h9a
`define WDT_SVC_KEY 8'hac

// field layout of the status register
`define WDT_STAT_WRITTEN 21
`define WDT_STAT_OFF 22

// overflow exponents
`define WDT_EXP_RL 5'h0b
`define WDT_EXP_FX 5'h0d

// clock rates and derived tick dividers
`define WDT_CLK_MHZ 100
`define WDT_FRL_KHZ 480
`define WDT_FX_MHZ 10
`define WDT_FRL_DIV ((`WDT_CLK_MHZ * 1000) / `WDT_FRL_KHZ)
`define WDT_FX_DIV (`WDT_CLK_MHZ / `WDT_FX_MHZ)

// pause after STOP: typical figure, within 17 us to 67 us
`define WDT_PAUSE_US 34
`define WDT_PAUSE_CYC (`WDT_PAUSE_US * `WDT_CLK_MHZ)
`define WDT_PAUSE_MIN_US 17
`define WDT_PAUSE_MIN_CYC (`WDT_PAUSE_MIN_US * `WDT_CLK_MHZ)

`endif

// ---- rtl/wdt_tick.sv ----
/*
  Divider giving a one-cycle enable pulse every DIV cycles of ref_clk.
  Assumes DIV between 2 and 255.
*/
`timescale 1ns/1ps
module wdt_tick #(
  parameter logic [7:0] DIV = 8'h0a
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // enable pulse
  output logic tick
);

  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic next_tick;

  // wrap at DIV-1 and flag the wrap
  always_comb begin
    next_tick = (cnt == DIV - 8'h01);
    next_cnt = next_tick ? 8'h00 : cnt + 8'h01;
  end

  // registered so the pulse comes from a flop
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule

// ---- rtl/wdt_top.sv ----
/*
  Watchdog timer with write-once mode register, keyed service register and
  HALT/STOP handling, reached over a classic Wishbone slave.
  Assumes halt, stop, bit_op, xtal_src and osc_settled come from CPU logic
  on ref_clk; the option strap is a pin and is synchronised.
*/
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "wdt_regs.svh"
module wdt_top
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_adr,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // cpu status
  input wire logic bit_op,
  input wire logic halt,
  input wire logic stop,
  input wire logic xtal_src,
  input wire logic osc_settled,
  // factory option strap, high when the watchdog may be stopped
  input wire logic opt_stoppable_pin,
  // internal chip reset request
  output logic wdt_rst
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // overflow limit minus one for an interval code and clock source
  function automatic logic [20:0] last_count(input logic [2:0] code,
                                             input logic sys);
    logic [4:0] expo;
    expo = (sys ? `WDT_EXP_FX : `WDT_EXP_RL) + {2'b00, code};
    last_count = (21'h000001 << expo) - 21'h000001;
  endfunction

  // register hit at a given index, word aligned; wb_sel is not looked at here
  function automatic logic hit(input logic [31:0] adr, input logic [15:0] idx);
    hit = (adr == {14'h0000, idx, 2'b00});
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // clock enables

  logic rl_tick;
  logic fx_tick;

  wdt_tick #(.DIV(8'(`WDT_FRL_DIV))) u_rl_tick (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .tick(rl_tick)
  );

  wdt_tick #(.DIV(8'(`WDT_FX_DIV))) u_fx_tick (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .tick(fx_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // option strap: synchronised, then caught once after reset release

  logic opt_s1;
  logic opt_s2;
  logic opt_stop;
  logic [1:0] cap_cnt;
  logic next_opt_stop;
  logic [1:0] next_cap_cnt;

  // fixed-clock until caught, the safe reading of the strap
  always_comb begin
    next_opt_stop = opt_stop;
    next_cap_cnt = cap_cnt;
    if (cap_cnt != 2'h3) begin
      next_cap_cnt = cap_cnt + 2'h1;
      if (cap_cnt == 2'h2) begin
        next_opt_stop = opt_s2;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      opt_s1 <= 1'b0;
      opt_s2 <= 1'b0;
      opt_stop <= 1'b0;
      cap_cnt <= 2'h0;
    end else begin
      opt_s1 <= opt_stoppable_pin;
      opt_s2 <= opt_s1;
      opt_stop <= next_opt_stop;
      cap_cnt <= next_cap_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone decode

  logic fire;
  logic hit_mode;
  logic hit_svc;
  logic hit_stat;
  logic wr_mode;
  logic wr_svc;
  logic svc_key;
  logic svc_bad;

  // a write takes effect at the edge where ack is high
  always_comb begin
    fire = wb_cyc & wb_stb & wb_ack;
    hit_mode = hit(wb_adr, `WDT_MODE_IDX);
    hit_svc = hit(wb_adr, `WDT_SVC_IDX);
    hit_stat = hit(wb_adr, `WDT_STAT_IDX);
    wr_mode = fire & wb_we & hit_mode & wb_sel[0] & ~bit_op;
    wr_svc = fire & wb_we & hit_svc & wb_sel[0];
    svc_key = wr_svc & ~bit_op & (wb_dat_w[7:0] == `WDT_SVC_KEY);
    // any single-bit access to the service register or non-key write to it is misuse
    svc_bad = (fire & hit_svc & bit_op) | (wr_svc & ~svc_key);
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode register

  wdt_mode_t mode;
  wdt_mode_t next_mode;
  logic written;
  logic next_written;
  logic sys_sel;
  logic wdt_off;

  // fixed option keeps clock bits at 00, so it can never stop or switch
  always_comb begin
    next_mode = mode;
    next_written = written;
    if (wr_mode && !written) begin
      next_mode = wdt_mode_t'(wb_dat_w[7:0]);
      if (!opt_stop) begin
        next_mode.clk_sel_hi = 1'b0;
        next_mode.clk_sel_lo = 1'b0;
      end
      next_written = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= wdt_mode_t'(`WDT_MODE_RST);
      written <= 1'b0;
    end else begin
      mode <= next_mode;
      written <= next_written;
    end
  end

  // clock-select decode
  always_comb begin
    sys_sel = opt_stop & ~mode.clk_sel_hi & mode.clk_sel_lo;
    wdt_off = opt_stop & mode.clk_sel_hi;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sleep handling

  wdt_state_t state;
  wdt_state_t next_state;
  logic was_stop;
  logic next_was_stop;
  logic [11:0] pause_cnt;
  logic [11:0] next_pause_cnt;
  logic sleep;

  // only the stoppable option leaves ST_RUN
  always_comb begin
    sleep = halt | stop;
    next_state = state;
    next_was_stop = was_stop;
    next_pause_cnt = pause_cnt;
    unique case (state)
      ST_RUN: begin
        if (opt_stop && sleep) begin
          next_state = ST_SLEEP;
          next_was_stop = stop;
        end
      end
      ST_SLEEP: begin
        if (!sleep) begin
          next_pause_cnt = 12'(`WDT_PAUSE_CYC - 1);
          if (!was_stop) begin
            next_state = ST_RUN;
          end else if (sys_sel && xtal_src) begin
            next_state = ST_SETTLE;
          end else begin
            next_state = ST_PAUSE;
          end
        end
      end
      ST_SETTLE: begin
        if (sleep) begin
          next_state = ST_SLEEP;
        end else if (osc_settled) begin
          next_state = ST_PAUSE;
        end
      end
      ST_PAUSE: begin
        if (sleep) begin
          next_state = ST_SLEEP;
        end else if (pause_cnt == 12'h000) begin
          next_state = ST_RUN;
        end else begin
          next_pause_cnt = pause_cnt - 12'h001;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_RUN;
      was_stop <= 1'b0;
      pause_cnt <= 12'h000;
    end else begin
      state <= next_state;
      was_stop <= next_was_stop;
      pause_cnt <= next_pause_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter and internal reset

  logic [20:0] cnt;
  logic [20:0] next_cnt;
  logic [20:0] lim;
  logic cnt_en;
  logic clr;
  logic ovf;
  logic next_rst;

  // fixed option counts on every low-speed tick whatever the cpu does
  always_comb begin
    lim = last_count(mode.interval_sel, sys_sel);
    cnt_en = (sys_sel ? fx_tick : rl_tick) & ~wdt_off;
    if (opt_stop) begin
      cnt_en = cnt_en & (state == ST_RUN);
    end
    clr = (wr_mode & ~written) | svc_key;
    ovf = cnt_en & (cnt == lim);
    next_cnt = cnt;
    if (clr) begin
      next_cnt = 21'h000000;
    end else if (ovf) begin
      next_cnt = 21'h000000;
    end else if (cnt_en) begin
      next_cnt = cnt + 21'h000001;
    end
    // misuse resets are dropped once the first write stopped the timer
    next_rst = ovf | (~wdt_off & ((wr_mode & written) | svc_bad));
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 21'h000000;
      wdt_rst <= 1'b0;
    end else begin
      cnt <= next_cnt;
      wdt_rst <= next_rst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer: one wait state, ack drops the cycle after

  logic next_ack;
  logic [31:0] next_dat;

  // unmapped reads return zero and are still acknowledged
  always_comb begin
    next_ack = wb_cyc & wb_stb & ~wb_ack;
    next_dat = 32'h00000000;
    if (hit_mode) begin
      next_dat = {24'h000000, mode};
    end else if (hit_svc) begin
      next_dat = {24'h000000, `WDT_SVC_READ};
    end else if (hit_stat) begin
      next_dat = {9'h000, wdt_off, written, cnt};
      next_dat[24:23] = state;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack <= 1'b0;
      wb_dat_r <= 32'h00000000;
    end else begin
      wb_ack <= next_ack;
      wb_dat_r <= next_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [11:0] pause_len;
  logic [11:0] next_pause_len;

  // length of the current pause, kept apart from pause_cnt for the check
  always_comb begin
    next_pause_len = 12'h000;
    if (state == ST_PAUSE) begin
      next_pause_len = pause_len + 12'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pause_len <= 12'h000;
    end else begin
      pause_len <= next_pause_len;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  AST_OVF_RST: assert property (cnt_en && !clr && cnt == lim |=> wdt_rst && cnt == 0)
    else $error("overflow did not raise reset");
  AST_MODE_CLR: assert property (wr_mode && !written |=> cnt == 0 && written)
    else $error("mode write did not clear counter");
  AST_KEY_CLR: assert property (svc_key && !wr_mode |=> cnt == 0 && wdt_rst == $past(ovf))
    else $error("key write did not clear counter");
  AST_SECOND: assert property (wr_mode && written && !wdt_off |=> wdt_rst)
    else $error("second mode write not punished");
  AST_BADKEY: assert property (svc_bad && !wdt_off |=> wdt_rst)
    else $error("bad service access not punished");
  AST_SUPPRESS: assert property (wdt_off && $stable(mode) |=> !wdt_rst)
    else $error("reset raised while watchdog stopped");
  AST_FIXED_RUN: assert property (!opt_stop && rl_tick && !clr && cnt != lim
    |=> cnt == 21'($past(cnt) + 21'h000001))
    else $error("fixed option failed to count");
  AST_FIXCLK: assert property (!opt_stop |-> !sys_sel && !wdt_off
    && !mode.clk_sel_hi && !mode.clk_sel_lo)
    else $error("fixed option left low-speed clock");
  AST_FREEZE: assert property (opt_stop && state != ST_RUN && !clr |=> $stable(cnt))
    else $error("counter moved while frozen");
  AST_INIT: assert property (!written |-> mode.interval_sel == 3'b111)
    else $error("interval not maximal before first write");
  AST_PAUSE: assert property ($rose(state == ST_PAUSE) |-> (state == ST_PAUSE) [*8])
    else $error("pause after stop too short");
  AST_PAUSE_MIN: assert property (state == ST_PAUSE && next_state == ST_RUN
    |-> pause_len >= 12'(`WDT_PAUSE_MIN_CYC - 1))
    else $error("pause after stop shorter than minimum");

  COV_OVF: cover property (ovf);
  COV_PAUSE_DONE: cover property (state == ST_PAUSE ##1 state == ST_RUN);
  COV_KEY: cover property (svc_key);

endmodule

// ---- tb/tb.sv ----
/*
  Self-checking bench for wdt_top: register reads, servicing, misuse resets,
  counting rates, sleep handling and overflow on the system clock.
  Assumes the package and the register header are compiled and included first.
*/
`timescale 1ns/1ps
`include "wdt_regs.svh"
module tb;
  import wdt_pkg::*;
  localparam logic [31:0] A_MODE = 32'h0003fd20;
  localparam logic [31:0] A_SVC = 32'h0003fd24;
  localparam logic [31:0] A_STAT = 32'h0003fd28;
  logic ref_clk, rst_b, wb_cyc, wb_stb, wb_we, wb_ack, wdt_rst;
  logic bit_op, halt, stop, xtal_src, osc_settled, opt_stoppable_pin;
  logic [3:0] wb_sel;
  logic [31:0] wb_adr, wb_dat_w, wb_dat_r, rd, c1, c2;
  int err_count, check_count, n, k;
  int rst_seen = 0;

  wdt_top u_wdt_top (
    .ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_sel(wb_sel), .wb_adr(wb_adr), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .bit_op(bit_op), .halt(halt), .stop(stop), .xtal_src(xtal_src),
    .osc_settled(osc_settled), .opt_stoppable_pin(opt_stoppable_pin), .wdt_rst(wdt_rst)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock, reset pulse counter, hang guard
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // pulses are one cycle wide, so count them rather than poll
  always @(posedge ref_clk) begin
    if (wdt_rst === 1'b1) rst_seen <= rst_seen + 1;
  end

  // longest path is the system clock overflow, about 82k cycles
  initial begin
    repeat (98000) @(posedge ref_clk);
    err_count++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // unknown bits fail the range test too
  task automatic rng(input string what, input int lo, input int hi, input logic [31:0] got);
    check_count++;
    if ((^got === 1'bx) || got < lo || got > hi) begin
      err_count++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // one classic cycle; released only at the edge that sees ack
  task automatic wb(input logic we, input logic [31:0] adr, input logic [7:0] dat,
                    input logic bop, output logic [31:0] q);
    int w;
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= {24'h000000, dat};
    wb_sel <= 4'h1;
    bit_op <= bop;
    w = 0;
    do begin
      @(posedge ref_clk);
      w++;
    end while (wb_ack !== 1'b1);
    chk("bus ack wait", 32'h2, w);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    bit_op <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] adr, input logic [7:0] dat, input logic bop);
    logic [31:0] q;
    wb(1'b1, adr, dat, bop, q);
  endtask

  task automatic cnt(output logic [31:0] q);
    wb(1'b0, A_STAT, 8'h00, 1'b0, q);
    q = q & 32'h001fffff;
  endtask

  task automatic do_reset(input logic strap);
    rst_b <= 1'b0;
    opt_stoppable_pin <= strap;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // tests
  initial begin
    {rst_b, wb_cyc, wb_stb, wb_we, bit_op, halt, stop, xtal_src, osc_settled} = '0;
    opt_stoppable_pin = 1'b0;
    wb_sel = 4'h0;
    wb_adr = 32'h0;
    wb_dat_w = 32'h0;
    {err_count, check_count} = '0;
    // fixed clock variant
    do_reset(1'b0);
    wb(1'b0, A_MODE, 8'h00, 1'b0, rd);
    chk("mode after reset", {24'h0, `WDT_MODE_RST}, rd);
    wb(1'b0, A_SVC, 8'h00, 1'b0, rd);
    chk("service read", {24'h0, `WDT_SVC_READ}, rd);
    cnt(c1);
    repeat (1040) @(posedge ref_clk);
    cnt(c2);
    rng("low-speed rate", c1 + 4, c1 + 6, c2);
    halt <= 1'b1;
    stop <= 1'b1;
    cnt(c1);
    repeat (1040) @(posedge ref_clk);
    cnt(c2);
    rng("count in stop", c1 + 4, c1 + 6, c2);
    wr(A_SVC, `WDT_SVC_KEY, 1'b0);
    cnt(c1);
    rng("key in stop", 0, 1, c1);
    halt <= 1'b0;
    stop <= 1'b0;
    n = rst_seen;
    wr(A_MODE, 8'h7a, 1'b0);
    cnt(c1);
    rng("clear on mode write", 0, 1, c1);
    wb(1'b0, A_MODE, 8'h00, 1'b0, rd);
    chk("clock bits ignored", 32'h62, rd);
    wb(1'b0, A_STAT, 8'h00, 1'b0, rd);
    chk("mode written flag", 32'h1, {31'h0, rd[21]});
    repeat (500) @(posedge ref_clk);
    wr(A_SVC, `WDT_SVC_KEY, 1'b0);
    cnt(c1);
    rng("clear on key", 0, 1, c1);
    chk("no reset yet", n, rst_seen);
    wr(A_SVC, 8'h55, 1'b0);
    wr(A_MODE, 8'h67, 1'b0);
    wr(A_SVC, `WDT_SVC_KEY, 1'b1);
    repeat (3) @(posedge ref_clk);
    chk("misuse resets", n + 3, rst_seen);
    wb(1'b0, A_MODE, 8'h00, 1'b0, rd);
    chk("mode kept", 32'h62, rd);
    wb(1'b0, 32'h00000010, 8'h00, 1'b0, rd);
    chk("unmapped read", 32'h0, rd);
    $display("test fixed variant done");
    // stoppable variant on the system clock
    do_reset(1'b1);
    wr(A_MODE, 8'h68, 1'b0);
    wb(1'b0, A_MODE, 8'h00, 1'b0, rd);
    chk("mode system clock", 32'h68, rd);
    cnt(c1);
    repeat (100) @(posedge ref_clk);
    cnt(c2);
    rng("system clock rate", c1 + 9, c1 + 11, c2);
    halt <= 1'b1;
    repeat (20) @(posedge ref_clk);
    cnt(c1);
    repeat (200) @(posedge ref_clk);
    cnt(c2);
    chk("frozen in halt", c1, c2);
    halt <= 1'b0;
    repeat (50) @(posedge ref_clk);
    cnt(c2);
    rng("resume after halt", c1 + 4, c1 + 6, c2);
    xtal_src <= 1'b1;
    stop <= 1'b1;
    repeat (20) @(posedge ref_clk);
    cnt(c1);
    repeat (200) @(posedge ref_clk);
    stop <= 1'b0;
    repeat (500) @(posedge ref_clk);
    cnt(c2);
    chk("held until settled", c1, c2);
    osc_settled <= 1'b1;
    repeat (3000) @(posedge ref_clk);
    cnt(c2);
    chk("held in pause", c1, c2);
    repeat (600) @(posedge ref_clk);
    cnt(c2);
    rng("resume after stop", c1 + 17, c1 + 23, c2);
    n = rst_seen;
    wr(A_SVC, `WDT_SVC_KEY, 1'b0);
    k = 0;
    while (rst_seen == n && k < 90000) begin
      @(posedge ref_clk);
      k++;
    end
    rng("overflow cycles", 81900, 81945, k);
    chk("overflow reset", n + 1, rst_seen);
    $display("test stoppable variant done");
    // stopped by the first write
    do_reset(1'b1);
    n = rst_seen;
    wr(A_MODE, 8'h70, 1'b0);
    wb(1'b0, A_STAT, 8'h00, 1'b0, rd);
    chk("stopped flag", 32'h1, {31'h0, rd[22]});
    cnt(c1);
    repeat (300) @(posedge ref_clk);
    cnt(c2);
    chk("stopped count", c1, c2);
    wr(A_MODE, 8'h68, 1'b0);
    wr(A_SVC, 8'h11, 1'b0);
    wr(A_SVC, `WDT_SVC_KEY, 1'b1);
    repeat (3) @(posedge ref_clk);
    chk("misuse suppressed", n, rst_seen);
    $display("test stopped watchdog done");
    summarize();
  end
endmodule
